// ==== timer_pkg.sv ====
// Shared constants and types of the timer/event counter block
package timer_pkg;
  // Machine cycle timing
  localparam int          OSC_PER_MC = 12;
  localparam logic [3:0]  MC_LAST    = 4'(OSC_PER_MC - 1);
  localparam logic [3:0]  MC_RESET   = 4'h0;
  localparam int          PRESC_W    = 5;
  // Special function register addresses
  localparam logic [7:0]  ADDR_MODES = 8'h89;
  localparam logic [7:0]  ADDR_C0_LO = 8'h8a;
  localparam logic [7:0]  ADDR_C1_LO = 8'h8b;
  localparam logic [7:0]  ADDR_C0_HI = 8'h8c;
  localparam logic [7:0]  ADDR_C1_HI = 8'h8d;
  localparam logic [7:0]  ADDR_CTRL  = 8'hc8;
  localparam logic [7:0]  ADDR_CAP_LO = 8'hca;
  localparam logic [7:0]  ADDR_CAP_HI = 8'hcb;
  localparam logic [7:0]  ADDR_CNT_LO = 8'hcc;
  localparam logic [7:0]  ADDR_CNT_HI = 8'hcd;
  // Control register bit positions
  localparam int B_OVF  = 7;
  localparam int B_EXF  = 6;
  localparam int B_GPF  = 5;
  localparam int B_BAUD = 4;
  localparam int B_TEN  = 3;
  localparam int B_RUN  = 2;
  localparam int B_SRC  = 1;
  localparam int B_CPRL = 0;
  // Mode byte fields of the first two counters, 4 bits per counter
  localparam int MF_W = 4;
  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  MODES_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  typedef enum logic [1:0] {T2_OFF = 2'b00, T2_RELOAD = 2'b01, T2_CAPTURE = 2'b10, T2_BAUD = 2'b11} t2_mode_t;
  typedef enum logic [1:0] {M_PRESC = 2'b00, M_WIDE = 2'b01, M_AUTO8 = 2'b10, M_SPLIT = 2'b11} c01_mode_t;
endpackage

// ==== mc_tick_if.sv ====
// Machine cycle strobe shared by the counter modules
`timescale 1ns/10ps
interface mc_tick_if;
  logic mc_tick;
  modport src (output mc_tick);
  modport dst (input mc_tick);
endinterface

// ==== edge_sampler.sv ====
// Pin synchroniser and machine-cycle falling edge detector
`timescale 1ns/10ps
module edge_sampler
  import timer_pkg::*;
(
  input  wire logic i_clk,     // Oscillator clock
  input  wire logic i_reset_n, // Async reset
  mc_tick_if.dst    tick,      // Machine cycle strobe
  input  wire logic i_pin,     // Raw pin
  output logic      o_fall     // One-clock edge pulse
);
  typedef struct packed {
    logic [2:0] sync;
    logic       level;
    logic       samp;
    logic       fall;
  } es_t;
  es_t r_reg;
  es_t r_next;

  ////////////////////////////////////////////////////////////
  // Level filter, then one sample per machine cycle
  always_comb
  begin
    r_next = r_reg;
    r_next.sync = {r_reg.sync[1:0], i_pin};
    if (r_reg.sync[1] == r_reg.sync[2])
      r_next.level = r_reg.sync[2];
    // Edge needs a high sample then a low one: two machine cycles
    r_next.fall = tick.mc_tick & r_reg.samp & ~r_reg.level;
    if (tick.mc_tick)
      r_next.samp = r_reg.level;
  end

  // Idle high so reset never fakes an edge
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      r_reg <= '{sync: 3'h7, level: 1'b1, samp: 1'b1, fall: 1'b0};
    else
      r_reg <= r_next;
  end
  assign o_fall = r_reg.fall;

  edge_spacing_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    r_reg.fall |=> !r_reg.fall [*8]) else $error("edge pulses closer than a machine cycle");
endmodule

// ==== counter_pair_unit.sv ====
// One of the first two counters, four modes
`timescale 1ns/10ps
module counter_pair_unit
  import timer_pkg::*;
(
  input  wire logic       i_clk,      // Oscillator clock
  input  wire logic       i_reset_n,  // Async reset
  mc_tick_if.dst          tick,       // Machine cycle strobe
  input  wire logic [1:0] i_mode,     // Mode select
  input  wire logic       i_ext,      // Count pin edges, not cycles
  input  wire logic       i_fall,     // Pin edge pulse
  input  wire logic       i_run,      // Run
  input  wire logic       i_hi_run,   // Run of split high byte
  input  wire logic       i_split_ok, // Split mode allowed
  input  wire logic       i_wr_lo,    // Write low byte
  input  wire logic       i_wr_hi,    // Write high byte
  input  wire logic [7:0] i_wdata,    // Write data
  output logic [7:0]      o_low,      // Low byte
  output logic [7:0]      o_high,     // High byte
  output logic            o_ovf,      // Overflow pulse
  output logic            o_ovf_hi    // Split high byte overflow
);
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
    logic       ovf_hi;
  } cu_t;
  cu_t r_reg;
  cu_t r_next;
  logic inc;
  c01_mode_t mode;
  assign mode = c01_mode_t'(i_mode);
  assign inc = i_run & (i_ext ? i_fall : tick.mc_tick);

  ////////////////////////////////////////////////////////////
  // Counting per mode, software writes win
  always_comb
  begin
    r_next = r_reg;
    r_next.ovf = 1'b0;
    r_next.ovf_hi = 1'b0;
    unique case (mode)
      M_PRESC:
        if (inc)
        begin
          r_next.lo[PRESC_W-1:0] = r_reg.lo[PRESC_W-1:0] + 5'h01;
          if (&r_reg.lo[PRESC_W-1:0])
          begin
            r_next.hi = r_reg.hi + 8'h01;
            r_next.ovf = &r_reg.hi;
          end
        end
      M_WIDE:
        if (inc)
        begin
          {r_next.hi, r_next.lo} = {r_reg.hi, r_reg.lo} + 16'h0001;
          r_next.ovf = &{r_reg.hi, r_reg.lo};
        end
      M_AUTO8:
        if (inc)
        begin
          r_next.lo = (&r_reg.lo) ? r_reg.hi : r_reg.lo + 8'h01;
          r_next.ovf = &r_reg.lo;
        end
      M_SPLIT:
        if (i_split_ok)
        begin
          // Two independent bytes; the high one only times cycles
          if (inc)
          begin
            r_next.lo = r_reg.lo + 8'h01;
            r_next.ovf = &r_reg.lo;
          end
          if (i_hi_run & tick.mc_tick)
          begin
            r_next.hi = r_reg.hi + 8'h01;
            r_next.ovf_hi = &r_reg.hi;
          end
        end
    endcase
    if (i_wr_lo)
      r_next.lo = i_wdata;
    if (i_wr_hi)
      r_next.hi = i_wdata;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
  assign o_low = r_reg.lo;
  assign o_high = r_reg.hi;
  assign o_ovf = r_reg.ovf;
  assign o_ovf_hi = r_reg.ovf_hi;

  auto8_reload_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode == M_AUTO8 && inc && &r_reg.lo && !i_wr_lo) |=> (r_reg.lo == $past(r_reg.hi)) && r_reg.ovf)
    else $error("8-bit auto reload missed");
  presc_carry_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mode == M_PRESC && inc && r_reg.lo[4:0] != 5'h1f && !i_wr_hi) |=> $stable(r_reg.hi))
    else $error("prescaled high byte moved early");
endmodule

// ==== timer_event_counters.sv ====
// Three timer/event counters with special function register access
`timescale 1ns/10ps
module timer_event_counters
  import timer_pkg::*;
(
  input  wire logic       I_CLK,             // Oscillator, 25 MHz
  input  wire logic       I_RESET_N,         // Async reset, low
  input  wire logic [7:0] I_SFR_ADDR,        // Direct address
  input  wire logic       I_SFR_WE,          // Write strobe
  input  wire logic [7:0] I_SFR_WDATA,       // Write data
  output logic [7:0]      O_SFR_RDATA,       // Read data, next cycle
  input  wire logic       I_COUNT0_PIN,      // First counter pin
  input  wire logic       I_COUNT1_PIN,      // Second counter pin
  input  wire logic       I_EXTERNAL_COUNT_PIN, // Third counter pin
  input  wire logic       I_TRIGGER_PIN,     // Capture/reload pin
  output logic            O_FIRST_OVF,       // First counter overflow
  output logic            O_FIRST_HI_OVF,    // Split high byte overflow
  output logic            O_SECOND_OVF,      // Second counter overflow
  output logic            O_SERIAL_CLK_TICK, // Serial port clock pulse
  output logic            O_THIRD_IRQ        // Third counter request
);
  typedef struct packed {
    logic [3:0]  mc_cnt;
    logic [7:0]  ctrl;
    logic [7:0]  modes;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0]  rdata;
    logic        ser_tick;
  } top_t;
  top_t r_reg;
  top_t r_next;

  mc_tick_if  mc ();
  logic [3:0] pin_raw;
  logic [3:0] fall;
  logic [1:0] ovf01;
  logic [1:0] ovf_hi;
  logic [7:0] lo01 [2];
  logic [7:0] hi01 [2];
  t2_mode_t   mode;
  logic       inc3;
  logic       roll;
  logic       trig;
  logic       wr_ctrl;

  ////////////////////////////////////////////////////////////
  // Machine cycle strobe, one clock in twelve
  assign mc.mc_tick = (r_reg.mc_cnt == MC_LAST);

  // Pins sampled once per machine cycle; short pulses may be lost
  assign pin_raw = {I_TRIGGER_PIN, I_EXTERNAL_COUNT_PIN, I_COUNT1_PIN, I_COUNT0_PIN};
  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_pin
      edge_sampler u_es (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .tick      (mc.dst),
        .i_pin     (pin_raw[p]),
        .o_fall    (fall[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////
  // First two counters
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_cnt
      counter_pair_unit u_cu (
        .i_clk      (I_CLK),
        .i_reset_n  (I_RESET_N),
        .tick       (mc.dst),
        .i_mode     (r_reg.modes[c*MF_W +: 2]),
        .i_ext      (r_reg.modes[c*MF_W + 2]),
        .i_fall     (fall[c]),
        .i_run      (r_reg.modes[c*MF_W + 3]),
        .i_hi_run   (r_reg.modes[MF_W + 3]),
        .i_split_ok (c == 0),
        .i_wr_lo    (I_SFR_WE && I_SFR_ADDR == (c == 0 ? ADDR_C0_LO : ADDR_C1_LO)),
        .i_wr_hi    (I_SFR_WE && I_SFR_ADDR == (c == 0 ? ADDR_C0_HI : ADDR_C1_HI)),
        .i_wdata    (I_SFR_WDATA),
        .o_low      (lo01[c]),
        .o_high     (hi01[c]),
        .o_ovf      (ovf01[c]),
        .o_ovf_hi   (ovf_hi[c])
      );
    end
  endgenerate
  assign O_FIRST_OVF = ovf01[0];
  assign O_FIRST_HI_OVF = ovf_hi[0];
  assign O_SECOND_OVF = ovf01[1];

  ////////////////////////////////////////////////////////////
  // Third counter mode decode
  always_comb
  begin
    if (!r_reg.ctrl[B_RUN])
      mode = T2_OFF;
    else if (r_reg.ctrl[B_BAUD])
      mode = T2_BAUD;
    else if (r_reg.ctrl[B_CPRL])
      mode = T2_CAPTURE;
    else
      mode = T2_RELOAD;
  end

  // Count source, rollover and qualified trigger
  assign inc3 = (mode != T2_OFF) && (r_reg.ctrl[B_SRC] ? fall[2] : mc.mc_tick);
  assign roll = inc3 && (r_reg.cnt == 16'hffff);
  assign trig = fall[3] && r_reg.ctrl[B_TEN] && !r_reg.ctrl[B_BAUD] && (mode != T2_OFF);
  assign wr_ctrl = I_SFR_WE && (I_SFR_ADDR == ADDR_CTRL);

  ////////////////////////////////////////////////////////////
  // Next state: hardware first, then software writes; hardware flag sets follow control writes
  always_comb
  begin
    r_next = r_reg;
    r_next.mc_cnt = mc.mc_tick ? MC_RESET : r_reg.mc_cnt + 4'h1;
    // Counting
    if (inc3)
    begin
      if (!roll)
        r_next.cnt = r_reg.cnt + 16'h0001;
      else if (mode == T2_CAPTURE)
        r_next.cnt = WORD_RESET;
      else
        r_next.cnt = r_reg.cap;
    end
    // Trigger pin: reload beats a same-cycle increment
    if (trig && mode == T2_RELOAD)
      r_next.cnt = r_reg.cap;
    if (trig && mode == T2_CAPTURE)
      r_next.cap = r_reg.cnt;
    // Serial clock source select
    r_next.ser_tick = r_reg.ctrl[B_BAUD] ? (roll && mode == T2_BAUD) : ovf01[1];
    // Control writes: flags can only be cleared by software
    if (wr_ctrl)
    begin
      r_next.ctrl = I_SFR_WDATA;
      r_next.ctrl[B_OVF] = r_reg.ctrl[B_OVF] & I_SFR_WDATA[B_OVF];
      r_next.ctrl[B_EXF] = r_reg.ctrl[B_EXF] & I_SFR_WDATA[B_EXF];
    end
    // Hardware set wins over a clear in the same cycle
    if (roll && mode != T2_BAUD)
      r_next.ctrl[B_OVF] = 1'b1;
    if (trig)
      r_next.ctrl[B_EXF] = 1'b1;
    // Data byte writes from software take priority
    if (I_SFR_WE)
    begin
      unique case (I_SFR_ADDR)
        ADDR_MODES:  r_next.modes = I_SFR_WDATA;
        ADDR_CNT_LO: r_next.cnt[7:0] = I_SFR_WDATA;
        ADDR_CNT_HI: r_next.cnt[15:8] = I_SFR_WDATA;
        ADDR_CAP_LO: r_next.cap[7:0] = I_SFR_WDATA;
        ADDR_CAP_HI: r_next.cap[15:8] = I_SFR_WDATA;
        default:     r_next.modes = r_next.modes;
      endcase
    end
    // Registered read port, unmapped addresses read zero
    unique case (I_SFR_ADDR)
      ADDR_CTRL:   r_next.rdata = r_reg.ctrl;
      ADDR_MODES:  r_next.rdata = r_reg.modes;
      ADDR_CNT_LO: r_next.rdata = r_reg.cnt[7:0];
      ADDR_CNT_HI: r_next.rdata = r_reg.cnt[15:8];
      ADDR_CAP_LO: r_next.rdata = r_reg.cap[7:0];
      ADDR_CAP_HI: r_next.rdata = r_reg.cap[15:8];
      ADDR_C0_LO:  r_next.rdata = lo01[0];
      ADDR_C0_HI:  r_next.rdata = hi01[0];
      ADDR_C1_LO:  r_next.rdata = lo01[1];
      ADDR_C1_HI:  r_next.rdata = hi01[1];
      default:     r_next.rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      r_reg <= '{mc_cnt: MC_RESET, ctrl: CTRL_RESET, modes: MODES_RESET, cnt: WORD_RESET,
                 cap: WORD_RESET, rdata: 8'h00, ser_tick: 1'b0};
    else
      r_reg <= r_next;
  end

  // Outputs; interrupt enable lives outside this block
  assign O_SFR_RDATA = r_reg.rdata;
  assign O_SERIAL_CLK_TICK = r_reg.ser_tick;
  assign O_THIRD_IRQ = r_reg.ctrl[B_OVF] | r_reg.ctrl[B_EXF];

  ////////////////////////////////////////////////////////////
  // Checks
  mc_period_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mc.mc_tick |-> ##12 mc.mc_tick) else $error("machine cycle is not twelve clocks");

  timer_step_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (inc3 && !roll && !trig && !I_SFR_WE) |=> r_reg.cnt == $past(r_reg.cnt) + 16'h0001)
    else $error("third counter did not step");

  stop_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (!r_reg.ctrl[B_RUN] && !I_SFR_WE) |=> $stable(r_reg.cnt))
    else $error("third counter moved while stopped");

  reload_roll_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (mode == T2_RELOAD && roll && !I_SFR_WE) |=> (r_reg.cnt == $past(r_reg.cap)) && r_reg.ctrl[B_OVF])
    else $error("rollover reload missed");

  capture_wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (mode == T2_CAPTURE && roll && !trig && !I_SFR_WE) |=> r_reg.cnt == 16'h0000 && r_reg.ctrl[B_OVF])
    else $error("capture mode did not wrap to zero");

  capture_copy_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (mode == T2_CAPTURE && trig && !I_SFR_WE) |=> (r_reg.cap == $past(r_reg.cnt)) && r_reg.ctrl[B_EXF])
    else $error("trigger capture missed");

  trig_reload_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (mode == T2_RELOAD && trig && !I_SFR_WE) |=> r_reg.cnt == $past(r_reg.cap))
    else $error("trigger reload missed");

  baud_no_flag_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (r_reg.ctrl[B_BAUD] && !r_reg.ctrl[B_OVF]) |=> !r_reg.ctrl[B_OVF])
    else $error("overflow flag set in baud mode");

  trig_ignore_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (fall[3] && (!r_reg.ctrl[B_TEN] || r_reg.ctrl[B_BAUD]) && !r_reg.ctrl[B_EXF] && !wr_ctrl)
    |=> !r_reg.ctrl[B_EXF]) else $error("ignored trigger raised the flag");

  flag_sticky_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (r_reg.ctrl[B_EXF] && !wr_ctrl) |=> r_reg.ctrl[B_EXF] && O_THIRD_IRQ)
    else $error("external flag dropped without software");

  baud_tick_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (mode == T2_BAUD && roll) |=> O_SERIAL_CLK_TICK ##1 !O_SERIAL_CLK_TICK)
    else $error("baud overflow did not reach the serial clock");

  serial_alt_a: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
    (!r_reg.ctrl[B_BAUD] && ovf01[1] && !wr_ctrl) |=> O_SERIAL_CLK_TICK)
    else $error("second counter overflow not used as serial clock");

  capture_cov_c: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode == T2_CAPTURE && trig);
  reload_cov_c: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode == T2_RELOAD && roll);
  baud_cov_c: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
    mode == T2_BAUD && roll);
  clear_race_c: cover property (@(posedge I_CLK) disable iff (!I_RESET_N)
    wr_ctrl && trig && !I_SFR_WDATA[B_EXF]);
endmodule

// ==== pin_source_model.sv ====
// Model of the pin sources and the serial clock consumer
`timescale 1ns/10ps
module pin_source_model
  import timer_pkg::*;
(
  input  wire logic i_clk,         // Oscillator clock
  input  wire logic i_serial_tick, // Serial clock pulse
  output logic      o_count0,      // First counter pin
  output logic      o_count1,      // Second counter pin
  output logic      o_ext_count,   // Third counter pin
  output logic      o_trigger      // Capture/reload pin
);
  // Three machine cycles per level, margin over the one-cycle minimum
  localparam int LEVEL_CLKS = 3 * OSC_PER_MC;
  int ticks = 0;

  // Pins idle high so a quiet pin never reads as a fall
  initial
  begin
    o_count0    = 1'b1;
    o_count1    = 1'b1;
    o_ext_count = 1'b1;
    o_trigger   = 1'b1;
  end

  // Serial port side only counts clock pulses
  always @(posedge i_clk)
    if (i_serial_tick === 1'b1)
      ticks <= ticks + 1;

  ////////////////////////////////////////////////////////////////
  // One falling edge, each level held well past a machine cycle
  task automatic fall_edge(input logic trig);
    @(posedge i_clk);
    if (trig)
      o_trigger <= 1'b0;
    else
      o_ext_count <= 1'b0;
    repeat (LEVEL_CLKS) @(posedge i_clk);
    o_trigger   <= 1'b1;
    o_ext_count <= 1'b1;
    repeat (LEVEL_CLKS) @(posedge i_clk);
  endtask
endmodule

// ==== timer_event_counters_test.sv ====
// Self-checking bench of the timer/event counter block
`timescale 1ns/10ps
module timer_event_counters_test;
  import timer_pkg::*;
  logic        clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic        we;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        c0_pin;
  logic        c1_pin;
  logic        ext_pin;
  logic        trig_pin;
  logic        ser_tick;
  logic        irq;
  logic        sec_ovf;
  int          sec_pulses = 0;
  logic [7:0]  v;
  logic [7:0]  w;
  logic [15:0] d16;
  int          mismatches = 0;
  int          checked    = 0;
  int          cycles     = 0;

  timer_event_counters dut (
    .I_CLK                (clk),
    .I_RESET_N            (reset_n),
    .I_SFR_ADDR           (addr),
    .I_SFR_WE             (we),
    .I_SFR_WDATA          (wdata),
    .O_SFR_RDATA          (rdata),
    .I_COUNT0_PIN         (c0_pin),
    .I_COUNT1_PIN         (c1_pin),
    .I_EXTERNAL_COUNT_PIN (ext_pin),
    .I_TRIGGER_PIN        (trig_pin),
    .O_FIRST_OVF          (),
    .O_FIRST_HI_OVF       (),
    .O_SECOND_OVF         (sec_ovf),
    .O_SERIAL_CLK_TICK    (ser_tick),
    .O_THIRD_IRQ          (irq)
  );

  pin_source_model partner (
    .i_clk         (clk),
    .i_serial_tick (ser_tick),
    .o_count0      (c0_pin),
    .o_count1      (c1_pin),
    .o_ext_count   (ext_pin),
    .o_trigger     (trig_pin)
  );

  // 25 MHz oscillator
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Second counter overflow pulses, one clock each
  always @(posedge clk)
    if (sec_ovf === 1'b1)
      sec_pulses <= sec_pulses + 1;

  // Hang guard, far above the roughly 1600 clocks the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus cycles and comparison
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    we    <= 1'b1;
    wdata <= d;
    @(posedge clk);
    we    <= 1'b0;
  endtask

  // Data follows one edge after the address is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 d = rdata;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_registers;
    rd(ADDR_CTRL, v);
    chk(v, CTRL_RESET);
    rd(8'h80, v);
    chk(v, 8'h00);
    wr(ADDR_CTRL, 8'he3);
    rd(ADDR_CTRL, v);
    chk(v, 8'h23);
    wr(ADDR_CTRL, 8'h00);
  endtask

  // Reads 120 clocks apart see exactly ten machine cycles
  task automatic test_timer_rate;
    wr(ADDR_CTRL, 8'h04);
    rd(ADDR_CNT_LO, v);
    repeat (118) @(posedge clk);
    rd(ADDR_CNT_LO, w);
    chk(8'(w - v), 16'd10);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CNT_LO, v);
    repeat (118) @(posedge clk);
    rd(ADDR_CNT_LO, w);
    chk(w, v);
  endtask

  task automatic test_rollover;
    wr16(ADDR_CAP_LO, 16'h1234);
    wr16(ADDR_CNT_LO, 16'hfffe);
    wr(ADDR_CTRL, 8'h04);
    repeat (60) @(posedge clk);
    rd(ADDR_CNT_HI, v);
    chk(v, 8'h12);
    rd(ADDR_CTRL, v);
    chk(v, 8'h84);
    chk(irq, 1'b1);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_CTRL, v);
    chk(v, 8'h00);
    chk(irq, 1'b0);
    wr16(ADDR_CNT_LO, 16'hfffe);
    wr(ADDR_CTRL, 8'h05);
    repeat (60) @(posedge clk);
    rd(ADDR_CTRL, v);
    chk(v, 8'h85);
    rd(ADDR_CNT_HI, v);
    chk(v, 8'h00);
    wr(ADDR_CTRL, 8'h00);
  endtask

  task automatic test_counter_mode;
    wr16(ADDR_CNT_LO, 16'h0000);
    wr(ADDR_CTRL, 8'h06);
    repeat (3) partner.fall_edge(1'b0);
    rd16(ADDR_CNT_LO, d16);
    chk(d16, 16'h0003);
  endtask

  task automatic test_capture;
    wr16(ADDR_CAP_LO, 16'h0000);
    wr16(ADDR_CNT_LO, 16'habcd);
    wr(ADDR_CTRL, 8'h0f);
    partner.fall_edge(1'b1);
    rd16(ADDR_CAP_LO, d16);
    chk(d16, 16'habcd);
    rd(ADDR_CTRL, v);
    chk(v, 8'h4f);
    chk(irq, 1'b1);
    wr(ADDR_CTRL, 8'h07);
    wr16(ADDR_CNT_LO, 16'h1111);
    partner.fall_edge(1'b1);
    rd(ADDR_CTRL, v);
    chk(v, 8'h07);
    rd16(ADDR_CAP_LO, d16);
    chk(d16, 16'habcd);
  endtask

  task automatic test_reload_baud;
    wr16(ADDR_CAP_LO, 16'h5566);
    wr16(ADDR_CNT_LO, 16'h0001);
    wr(ADDR_CTRL, 8'h0e);
    partner.fall_edge(1'b1);
    rd16(ADDR_CNT_LO, d16);
    chk(d16, 16'h5566);
    rd(ADDR_CTRL, v);
    chk(v, 8'h4e);
    wr(ADDR_CTRL, 8'h1e);
    wr16(ADDR_CNT_LO, 16'h0001);
    partner.fall_edge(1'b1);
    rd16(ADDR_CNT_LO, d16);
    chk(d16, 16'h0001);
    wr(ADDR_CTRL, 8'h17);
    wr16(ADDR_CNT_LO, 16'hfffe);
    #1 partner.ticks = 0;
    repeat (2) partner.fall_edge(1'b0);
    rd16(ADDR_CNT_LO, d16);
    chk(d16, 16'h5566);
    rd(ADDR_CTRL, v);
    chk(v, 8'h17);
    chk(partner.ticks, 16'd1);
    wr(ADDR_CTRL, 8'h00);
  endtask

  // Reload 0xfc gives an overflow every 4 machine cycles, 5 in 240 clocks
  task automatic test_second_counter;
    wr(ADDR_C1_HI, 8'hfc);
    wr(ADDR_C1_LO, 8'hfc);
    wr(ADDR_MODES, 8'ha0);
    repeat (60) @(posedge clk);
    #1 partner.ticks = 0;
    sec_pulses = 0;
    repeat (240) @(posedge clk);
    #1 chk(partner.ticks, 16'd5);
    chk(sec_pulses, 16'd5);
    wr(ADDR_MODES, MODES_RESET);
  endtask

  // First counter as full 16-bit timer: ten steps in 120 clocks
  task automatic test_first_counter;
    wr16(ADDR_C0_LO, 16'h0000);
    wr(ADDR_MODES, 8'h09);
    rd(ADDR_C0_LO, v);
    repeat (118) @(posedge clk);
    rd(ADDR_C0_LO, w);
    chk(8'(w - v), 16'd10);
    wr(ADDR_MODES, MODES_RESET);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    addr    = 8'h00;
    we      = 1'b0;
    wdata   = 8'h00;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    test_registers();
    test_timer_rate();
    test_rollover();
    test_counter_mode();
    test_capture();
    test_reload_baud();
    test_second_counter();
    test_first_counter();
    results();
  end
endmodule
